//--- verilog/bpf_core.sv
// Branch predictor and fetch address sequencer of the core front end
//
// Overview of operation
// RL1 - Likely-class branches and direct jumps use a fixed taken prediction.
// RL2 - Ordinary conditionals use 9-bit history xor address into 4K counters.
// RL3 - A 16-entry fully associative buffer predicts register-indirect targets.
// RL4 - That buffer skips the register-31 jump; returns use the return stack.
// RL5 - A 4-entry return stack supplies the register-31 return target.
// RL6 - Fetch/decode spans 3 stages; branch target is known in the third.
// RL7 - Taken branch: fetch PC+16, PC+32, then target in cycle 3.
// RL8 - Correctly predicted taken conditionals still lose at least one cycle.
// RL9 - An unexpected redirect wastes about 10 instruction slots.
// RL10 - One branch decoded per cycle; a second branch stalls fetch once.
// RL11 - Calls linking register 31 push; predicted returns pop; stack wraps.
// RL12 - Resolution trains counters; decode shifts history, resolution restores it on mispredict.
`timescale 1ns/100ps
module bpf_core (
	input  wire logic                       CLOCK_I,
	input  wire logic                       NRST_I,
	input  wire logic                       CE_I,
	input  wire bpf_pkg::bpf_decode_s       DECODE_I,
	input  wire bpf_pkg::bpf_resolve_s      RESOLVE_I,
	output logic [bpf_pkg::ADDR_W-1:0]      FETCH_PC_O,
	output logic                            FETCH_STALL_O,
	output logic                            SQUASH_O,
	output bpf_pkg::bpf_pred_s              PRED_O
);
	localparam int AW = bpf_pkg::ADDR_W;
	localparam int HW = bpf_pkg::HIST_W;

	logic [AW-1:0]              pc_q, pc_d;
	logic [HW-1:0]              hist_q;
	logic [1:0]                 pht_q [bpf_pkg::PHT_ENTRIES];
	logic [AW-1:0]              itb_tag_q [bpf_pkg::ITB_ENTRIES];
	logic [AW-1:0]              itb_tgt_q [bpf_pkg::ITB_ENTRIES];
	logic [bpf_pkg::ITB_ENTRIES-1:0] itb_vld_q;
	logic [bpf_pkg::ITB_ENTRIES-1:0] itb_hit;
	logic [bpf_pkg::ITB_ENTRIES-1:0] itb_upd_hit;
	logic [bpf_pkg::ITB_IDX_W-1:0]   itb_rr_q;
	logic [AW-1:0]              ras_q [bpf_pkg::RAS_ENTRIES];
	logic [bpf_pkg::RAS_IDX_W-1:0]   ras_top_q;
	logic                       dual_done_q;
	bpf_pkg::bpf_state_e        state_q;
	logic [bpf_pkg::PEN_W-1:0]  pen_q;

	logic [bpf_pkg::PHT_IDX_W-1:0] pred_idx, upd_idx;
	logic                       pred_taken;
	logic [AW-1:0]              pred_tgt;
	logic                       itb_any;
	logic [AW-1:0]              itb_sel;
	logic                       dual_stall;
	logic                       redirect;
	logic                       is_cond;
	logic                       upd_cond;
	logic                       upd_ind;

	assign is_cond  = DECODE_I.valid && DECODE_I.kind == bpf_pkg::BR_COND;
	assign upd_cond = RESOLVE_I.valid && RESOLVE_I.kind == bpf_pkg::BR_COND;
	assign upd_ind  = RESOLVE_I.valid &&
		RESOLVE_I.kind == bpf_pkg::BR_INDIRECT && RESOLVE_I.taken;
	assign redirect = RESOLVE_I.valid && RESOLVE_I.mispredict;
	// Shared index: address bits folded with the global history [RL2]
	assign pred_idx = DECODE_I.pc[bpf_pkg::PC_IDX_LSB +: bpf_pkg::PHT_IDX_W]
		^ bpf_pkg::PHT_IDX_W'(hist_q);
	assign upd_idx = RESOLVE_I.pc[bpf_pkg::PC_IDX_LSB +: bpf_pkg::PHT_IDX_W]
		^ bpf_pkg::PHT_IDX_W'(RESOLVE_I.hist);

	// Associative match, one decode and one resolve comparator per entry [RL3]
	genvar g;
	generate
		for (g = 0; g < bpf_pkg::ITB_ENTRIES; g++) begin : g_itb
			assign itb_hit[g] = itb_vld_q[g] &&
				itb_tag_q[g] == DECODE_I.pc;
			assign itb_upd_hit[g] = itb_vld_q[g] &&
				itb_tag_q[g] == RESOLVE_I.pc;
		end
	endgenerate

	always_comb begin
		itb_sel = '0;
		for (int i = 0; i < bpf_pkg::ITB_ENTRIES; i++) begin
			if (itb_hit[i]) begin
				itb_sel = itb_sel | itb_tgt_q[i];
			end
		end
	end
	assign itb_any = |itb_hit;

	// Prediction is formed in the third stage, where the target exists [RL6]
	always_comb begin
		pred_taken = 1'b0;
		pred_tgt   = DECODE_I.imm_target;
		case (DECODE_I.kind)
			bpf_pkg::BR_LIKELY,
			bpf_pkg::BR_JUMP: begin
				pred_taken = DECODE_I.valid; // [RL1]
			end
			bpf_pkg::BR_COND: begin
				pred_taken = DECODE_I.valid &&
					pht_q[pred_idx][bpf_pkg::CTR_DIR_BIT]; // [RL2]
			end
			bpf_pkg::BR_INDIRECT: begin
				// A miss falls through; execution corrects it [RL4]
				pred_taken = DECODE_I.valid && itb_any;
				pred_tgt   = itb_sel; // [RL3]
			end
			bpf_pkg::BR_RETURN: begin
				pred_taken = DECODE_I.valid;
				pred_tgt   = ras_q[ras_top_q - 2'h1]; // [RL5]
			end
			default: begin
				pred_taken = 1'b0;
			end
		endcase
	end

	// The decoder takes one branch a cycle; the second costs a hold [RL10]
	assign dual_stall = DECODE_I.valid && DECODE_I.second_branch &&
		!dual_done_q;

	always_comb begin
		pc_d = pc_q + bpf_pkg::GROUP_STEP; // [RL7]
		if (redirect) begin
			pc_d = RESOLVE_I.next_pc; // [RL9]
		end else if (state_q == bpf_pkg::ST_PENALTY || dual_stall) begin
			pc_d = pc_q;
		end else if (pred_taken) begin
			// Two sequential groups already fetched, so cycle 3 [RL7] [RL8]
			pc_d = pred_tgt;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			pc_q <= bpf_pkg::RESET_PC;
		end else if (CE_I) begin
			pc_q <= pc_d;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			dual_done_q <= 1'b0;
		end else if (CE_I) begin
			dual_done_q <= dual_stall && !redirect; // [RL10]
		end
	end

	// Redirect penalty: fetch idles for the slots lost [RL9]
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			state_q <= bpf_pkg::ST_RUN;
			pen_q   <= '0;
		end else if (CE_I) begin
			case (state_q)
				bpf_pkg::ST_RUN: begin
					if (redirect) begin
						state_q <= bpf_pkg::ST_PENALTY;
						pen_q   <= bpf_pkg::PEN_LOAD;
					end
				end
				bpf_pkg::ST_PENALTY: begin
					if (redirect) begin
						pen_q <= bpf_pkg::PEN_LOAD;
					end else if (pen_q == '0) begin
						state_q <= bpf_pkg::ST_RUN;
					end else begin
						pen_q <= pen_q - 1'b1;
					end
				end
				default: begin
					state_q <= bpf_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Speculative history shift; rebuilt from the snapshot on mispredict
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			hist_q <= bpf_pkg::HIST_RESET;
		end else if (CE_I) begin
			if (redirect && upd_cond) begin
				hist_q <= {RESOLVE_I.hist[HW-2:0], RESOLVE_I.taken}; // [RL12]
			end else if (redirect) begin
				hist_q <= RESOLVE_I.hist; // [RL12]
			end else if (is_cond && !dual_stall &&
				state_q == bpf_pkg::ST_RUN) begin
				hist_q <= {hist_q[HW-2:0], pred_taken}; // [RL2]
			end
		end
	end

	// Saturating two-bit counters, one per entry
	generate
		for (g = 0; g < bpf_pkg::PHT_ENTRIES; g++) begin : g_pht
			always_ff @(posedge CLOCK_I) begin
				if (!NRST_I) begin
					pht_q[g] <= bpf_pkg::CTR_RESET;
				end else if (CE_I && upd_cond &&
					upd_idx == bpf_pkg::PHT_IDX_W'(g)) begin
					if (RESOLVE_I.taken && pht_q[g] != bpf_pkg::CTR_MAX) begin
						pht_q[g] <= pht_q[g] + 2'h1; // [RL12]
					end else if (!RESOLVE_I.taken &&
						pht_q[g] != bpf_pkg::CTR_MIN) begin
						pht_q[g] <= pht_q[g] - 2'h1; // [RL12]
					end
				end
			end
		end
	endgenerate

	// Indirect buffer fill: refresh a hit, else replace round robin
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			itb_vld_q <= '0;
			itb_rr_q  <= '0;
			for (int i = 0; i < bpf_pkg::ITB_ENTRIES; i++) begin
				itb_tag_q[i] <= '0;
				itb_tgt_q[i] <= '0;
			end
		end else if (CE_I && upd_ind) begin
			if (|itb_upd_hit) begin
				for (int i = 0; i < bpf_pkg::ITB_ENTRIES; i++) begin
					if (itb_upd_hit[i]) begin
						itb_tgt_q[i] <= RESOLVE_I.next_pc; // [RL3]
					end
				end
			end else begin
				itb_vld_q[itb_rr_q] <= 1'b1;
				itb_tag_q[itb_rr_q] <= RESOLVE_I.pc;
				itb_tgt_q[itb_rr_q] <= RESOLVE_I.next_pc; // [RL3]
				itb_rr_q            <= itb_rr_q + 1'b1;
			end
		end
	end

	// Return stack is a ring: overflow overwrites the oldest entry
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			ras_top_q <= '0;
			for (int i = 0; i < bpf_pkg::RAS_ENTRIES; i++) begin
				ras_q[i] <= '0;
			end
		end else if (CE_I && DECODE_I.valid && !dual_stall &&
			state_q == bpf_pkg::ST_RUN && !redirect) begin
			if (DECODE_I.link31) begin
				ras_q[ras_top_q] <= DECODE_I.link_addr; // [RL11]
				ras_top_q        <= ras_top_q + 2'h1;
			end else if (DECODE_I.kind == bpf_pkg::BR_RETURN) begin
				ras_top_q <= ras_top_q - 2'h1; // [RL11]
			end
		end
	end

	// Registered view of fetch for the pipeline
	always_ff @(posedge CLOCK_I) begin
		if (!NRST_I) begin
			FETCH_PC_O    <= bpf_pkg::RESET_PC;
			FETCH_STALL_O <= 1'b0;
			SQUASH_O      <= 1'b0;
			PRED_O        <= '0;
		end else if (CE_I) begin
			FETCH_PC_O    <= pc_d;
			FETCH_STALL_O <= !redirect &&
				(state_q == bpf_pkg::ST_PENALTY || dual_stall);
			// Kill the two wrong-path groups behind a taken branch [RL7]
			SQUASH_O      <= redirect || (pred_taken && !dual_stall &&
				state_q == bpf_pkg::ST_RUN);
			// A held or refused decode hands on no prediction
			PRED_O.valid  <= DECODE_I.valid && !redirect && !dual_stall &&
				state_q == bpf_pkg::ST_RUN;
			PRED_O.taken  <= pred_taken;
			PRED_O.target <= pred_tgt;
			PRED_O.hist   <= hist_q;
		end
	end
endmodule : bpf_core

//--- verilog/bpf_pkg.sv
// Shared types and constants for the branch prediction and fetch redirect
package bpf_pkg;
	localparam int          ADDR_W        = 32;
	localparam int          HIST_W        = 9;
	localparam int          PHT_IDX_W     = 12;
	localparam int          PHT_ENTRIES   = 4096;
	localparam int          ITB_ENTRIES   = 16;
	localparam int          ITB_IDX_W     = 4;
	localparam int          RAS_ENTRIES   = 4;
	localparam int          RAS_IDX_W     = 2;
	localparam int          FD_STAGES     = 3;
	localparam int          FETCH_SLOTS   = 4;
	localparam int          REDIR_SLOTS   = 10;
	// Whole fetch cycles lost on an unexpected redirect, rounded up
	localparam int          REDIR_CYC     =
		(REDIR_SLOTS + FETCH_SLOTS - 1) / FETCH_SLOTS;
	localparam int          PEN_W         = 3;
	localparam logic [PEN_W-1:0] PEN_LOAD = PEN_W'(REDIR_CYC - 1);
	localparam logic [ADDR_W-1:0] GROUP_STEP = 32'h0000_0010;
	localparam logic [ADDR_W-1:0] RESET_PC   = 32'h0000_0000;
	localparam logic [1:0]  CTR_RESET     = 2'h1;
	localparam logic [1:0]  CTR_MAX       = 2'h3;
	localparam logic [1:0]  CTR_MIN       = 2'h0;
	localparam int          CTR_DIR_BIT   = 1;
	localparam int          PC_IDX_LSB    = 2;
	localparam logic [HIST_W-1:0] HIST_RESET = 9'h000;

	typedef enum logic [2:0] {
		BR_NONE,
		BR_COND,
		BR_LIKELY,
		BR_JUMP,
		BR_INDIRECT,
		BR_RETURN
	} bpf_kind_e;

	typedef enum logic {
		ST_RUN,
		ST_PENALTY
	} bpf_state_e;

	// One branch seen by the third fetch/decode stage
	typedef struct packed {
		logic              valid;
		bpf_kind_e         kind;
		logic [ADDR_W-1:0] pc;
		logic [ADDR_W-1:0] imm_target;
		logic              link31;
		logic [ADDR_W-1:0] link_addr;
		logic              second_branch;
	} bpf_decode_s;

	// A branch resolved by execution
	typedef struct packed {
		logic              valid;
		bpf_kind_e         kind;
		logic [ADDR_W-1:0] pc;
		logic              taken;
		logic [ADDR_W-1:0] next_pc;
		logic              mispredict;
		logic [HIST_W-1:0] hist;
	} bpf_resolve_s;

	// Prediction handed on with the branch
	typedef struct packed {
		logic              valid;
		logic              taken;
		logic [ADDR_W-1:0] target;
		logic [HIST_W-1:0] hist;
	} bpf_pred_s;
endpackage : bpf_pkg

//--- bench/bpf_core_sva.sv
// Checker of the branch prediction and fetch redirect block
`timescale 1ns/100ps
module bpf_core_sva (
	input wire logic                       CLOCK_I,
	input wire logic                       NRST_I,
	input wire logic                       CE_I,
	input wire bpf_pkg::bpf_decode_s       DECODE_I,
	input wire bpf_pkg::bpf_resolve_s      RESOLVE_I,
	input wire logic [bpf_pkg::ADDR_W-1:0] FETCH_PC_O,
	input wire logic                       FETCH_STALL_O,
	input wire logic                       SQUASH_O,
	input wire bpf_pkg::bpf_pred_s         PRED_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!NRST_I);
	// Decode is checked only outside stall, squash and resolve cycles
	wire logic idle = CE_I && !FETCH_STALL_O && !SQUASH_O && !RESOLVE_I.valid;
	wire logic dv   = DECODE_I.valid && !DECODE_I.second_branch;

	a_seq_advance: assert property (
		idle && !DECODE_I.valid |=> FETCH_STALL_O ||
		FETCH_PC_O == $past(FETCH_PC_O) + bpf_pkg::GROUP_STEP)
		else $error("fetch address did not step one group");
	a_static_taken: assert property (
		idle && dv && DECODE_I.kind inside {bpf_pkg::BR_JUMP,
		bpf_pkg::BR_LIKELY} |=> SQUASH_O && PRED_O.taken &&
		FETCH_PC_O == $past(DECODE_I.imm_target))
		else $error("static branch not redirected");
	a_cond_lost_cycle: assert property (
		idle && dv && DECODE_I.kind == bpf_pkg::BR_COND
		|=> SQUASH_O == PRED_O.taken)
		else $error("taken conditional without squash");
	a_pred_third_stage: assert property (
		idle && dv |=> PRED_O.valid)
		else $error("no prediction one cycle after decode");
	a_two_branch_stall: assert property (
		idle && DECODE_I.valid && DECODE_I.second_branch
		|=> FETCH_STALL_O && $stable(FETCH_PC_O))
		else $error("second branch did not stall fetch");
	a_redirect_penalty: assert property (
		CE_I && RESOLVE_I.valid && RESOLVE_I.mispredict |=> SQUASH_O &&
		FETCH_PC_O == $past(RESOLVE_I.next_pc) ##1 FETCH_STALL_O[*3]
		##1 !FETCH_STALL_O)
		else $error("mispredict penalty wrong");
	a_stall_holds_pc: assert property (
		FETCH_STALL_O |-> $stable(FETCH_PC_O))
		else $error("fetch address moved while stalled");
	a_squash_pulse: assert property (
		SQUASH_O && CE_I && !RESOLVE_I.valid |=> !SQUASH_O)
		else $error("squash longer than one cycle");

	c_return: cover property (idle && dv &&
		DECODE_I.kind == bpf_pkg::BR_RETURN);
	c_mispredict: cover property (RESOLVE_I.valid && RESOLVE_I.mispredict);
	c_two_branch: cover property (FETCH_STALL_O && DECODE_I.second_branch);
endmodule : bpf_core_sva

bind bpf_core bpf_core_sva i_sva (.CLOCK_I, .NRST_I, .CE_I, .DECODE_I,
	.RESOLVE_I, .FETCH_PC_O, .FETCH_STALL_O, .SQUASH_O, .PRED_O);

//--- bench/bpf_fetch_model.sv
// Model of the fetch and decode stages that feed the predictor
`timescale 1ns/100ps
module bpf_fetch_model (
	input  wire logic             clk_i,
	output bpf_pkg::bpf_decode_s  dec_o,
	output bpf_pkg::bpf_resolve_s res_o
);
	initial dec_o = '0;
	initial res_o = '0;
	// A two-branch group stays for a second decode cycle
	task automatic branch(input bpf_pkg::bpf_decode_s d);
		@(posedge clk_i);
		dec_o <= d;
		@(posedge clk_i);
		if (d.second_branch)
			@(posedge clk_i);
		// Released fields flip so stale values are never trusted
		d = bpf_pkg::bpf_decode_s'(~d);
		d.valid = 1'b0;
		dec_o <= d;
	endtask : branch
	// One-cycle resolution pulse, after a chosen execute delay
	task automatic resolve(input bpf_pkg::bpf_resolve_s r, input int lag);
		repeat (lag) @(posedge clk_i);
		@(posedge clk_i);
		res_o <= r;
		@(posedge clk_i);
		r = bpf_pkg::bpf_resolve_s'(~r);
		r.valid = 1'b0;
		res_o <= r;
	endtask : resolve
endmodule : bpf_fetch_model

//--- bench/tb.sv
// Self-checking testbench of the branch prediction and fetch redirect block
`timescale 1ns/100ps
module tb;
	logic                  clk = 1'b0;
	logic                  nrst = 1'b0;
	logic                  ce = 1'b0;
	bpf_pkg::bpf_decode_s  dec;
	bpf_pkg::bpf_resolve_s res;
	logic [31:0]           pc;
	logic                  stall;
	logic                  squash;
	bpf_pkg::bpf_pred_s    pred;
	int                    fail_count = 0;
	int                    samples_checked = 0;
	int                    stall_n = 0;

	always #5 clk = ~clk;
	// Counted mid-cycle, where the registered stall has settled
	always @(negedge clk) if (stall) stall_n++;

	bpf_fetch_model i_model (.clk_i(clk), .dec_o(dec), .res_o(res));
	bpf_core i_bpf_core (.CLOCK_I(clk), .NRST_I(nrst), .CE_I(ce),
		.DECODE_I(dec), .RESOLVE_I(res), .FETCH_PC_O(pc),
		.FETCH_STALL_O(stall), .SQUASH_O(squash), .PRED_O(pred));

	task automatic check(input string n, input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	// Call return address is the branch address plus 8
	task automatic go(input bpf_pkg::bpf_kind_e k, input logic [31:0] a, t,
			input logic l, sb);
		bpf_pkg::bpf_decode_s d;
		d = '{1'b1, k, a, t, l, a + 32'h0000_0008, sb};
		i_model.branch(d);
		#1;
	endtask : go
	task automatic rs(input bpf_pkg::bpf_kind_e k, input logic [31:0] a, n,
			input logic [8:0] h, input int lag);
		bpf_pkg::bpf_resolve_s r;
		r = '{1'b1, k, a, 1'b1, n, 1'b1, h};
		i_model.resolve(r, lag);
		#1;
	endtask : rs

	task automatic t_seq;
		logic [31:0] p;
		@(posedge clk);
		#1;
		p = pc;
		@(posedge clk);
		#1;
		check("seq", pc, p + 32'h0000_0010);
	endtask : t_seq
	task automatic t_ras;
		// Five calls overflow the four-entry ring; the oldest is lost
		for (int i = 1; i < 6; i++) begin
			go(bpf_pkg::BR_JUMP, 32'h0000_0100 * i, 32'h0000_1000, 1'b1, 1'b0);
			check("jump", pc, 32'h0000_1000);
			check("squash", squash, 1'b1);
		end
		go(bpf_pkg::BR_LIKELY, 32'h0000_0900, 32'h0000_0A00, 1'b0, 1'b0);
		check("likely", pc, 32'h0000_0A00);
		for (int i = 5; i > 1; i--) begin
			go(bpf_pkg::BR_RETURN, 32'h0000_2000, '0, 1'b0, 1'b0);
			check("ret", pc, 32'h0000_0100 * i + 32'h0000_0008);
		end
	endtask : t_ras
	task automatic t_cond;
		int n;
		go(bpf_pkg::BR_COND, 32'h0000_0100, 32'h0000_3000, 1'b0, 1'b0);
		check("nt", pred.taken, 1'b0);
		check("hist0", pred.hist, 9'h000);
		rs(bpf_pkg::BR_COND, 32'h0000_0100, 32'h0000_3000, 9'h000, 0);
		check("redir", pc, 32'h0000_3000);
		n = stall_n;
		repeat (5) @(posedge clk);
		#1;
		check("stalls", stall_n - n, bpf_pkg::REDIR_CYC);
		// Same counter through the shifted history
		go(bpf_pkg::BR_COND, 32'h0000_0104, 32'h0000_3400, 1'b0, 1'b0);
		check("tk", pc, 32'h0000_3400);
		check("hist1", pred.hist, 9'h001);
	endtask : t_cond
	task automatic t_two;
		int n;
		n = stall_n;
		go(bpf_pkg::BR_COND, 32'h0000_0500, 32'h0000_0600, 1'b0, 1'b1);
		check("second", pred.valid, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		check("stall1", stall_n - n, 1);
	endtask : t_two
	task automatic t_ind;
		go(bpf_pkg::BR_INDIRECT, 32'h0000_0700, '0, 1'b0, 1'b0);
		check("miss", pred.taken, 1'b0);
		rs(bpf_pkg::BR_INDIRECT, 32'h0000_0700, 32'h0000_5000, pred.hist, 2);
		repeat (5) @(posedge clk);
		go(bpf_pkg::BR_INDIRECT, 32'h0000_0700, '0, 1'b0, 1'b0);
		check("hit", pc, 32'h0000_5000);
		check("tgt", pred.target, 32'h0000_5000);
		// A mispredicted return must not train the indirect buffer
		rs(bpf_pkg::BR_RETURN, 32'h0000_0800, 32'h0000_6000, pred.hist, 0);
		check("ret_redir", pc, 32'h0000_6000);
		repeat (5) @(posedge clk);
		go(bpf_pkg::BR_INDIRECT, 32'h0000_0800, '0, 1'b0, 1'b0);
		check("no_ret_fill", pred.taken, 1'b0);
	endtask : t_ind

	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		ce <= 1'b1;
		t_seq;
		t_ras;
		t_cond;
		t_two;
		t_ind;
		conclude;
	end
	// A run of under a hundred cycles, so this only trips on a hang
	initial begin
		#20000;
		fail_count++;
		conclude;
	end
endmodule : tb
